// ===== logic/rwt_watchdog_timer.sv
// Contract
// - 10-bit up counter overflow raises nmi or reset
// - timeout is 131072 low-speed source periods after restart
// - 2-bit source select, low-speed default
// - source/divider writable only while clock disabled
// - low-speed source divides by 128 only
// - rc/high-speed divided by 4096 to 32768
// - enable key 1010 stops count clock
// - stopped clock freezes counter, registers stay accessible
// - selected oscillator may not be stopped
// - action select 0 nmi, 1 reset
// - run key 1010 halts counter, resets stopped
// - restart bit clears counter, reads zero
// - nmi overflow sets flag, restart clears
// - counting and overflow continue in halt
// - sleep holds back the overflow output
// - reserved bits read zero, registers 8 bit
// - overflow sets flag in reset mode too
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
module rwt_watchdog_timer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        internal_rc_osc,
    input  wire logic        low_speed_osc,
    input  wire logic        high_speed_osc,
    input  wire logic        cpu_sleep,
    input  wire logic [2:0]  osc_stop_req,
    output logic      [2:0]  osc_stop_grant,
    output logic             nmi_out,
    output logic             reset_out
);

    // ======================================================================
    // declarations
    // ======================================================================
    rwt_pkg::rwt_clk_sel_t clk_sel_reg;             // clock select register
    rwt_pkg::rwt_ctrl_t    ctrl_reg;                // run key and action
    logic                  flag_reg;                // overflow nmi flag
    logic                  wr_pend_reg;             // write in data phase
    logic [29:0]           wr_idx_reg;              // its register index
    logic [2:0]            osc_s1_reg;              // first sync stage
    logic [2:0]            osc_s2_reg;              // second sync stage
    logic [2:0]            osc_s3_reg;              // edge detect history
    logic [14:0]           pre_reg;                 // divider counter
    logic [9:0]            count_reg;               // watchdog up counter
    logic                  ovf_reg;                 // overflow event pulse
    logic                  pend_reg;                // overflow waiting on sleep
    logic                  sleep_s1_reg;            // sleep sync stages
    logic                  sleep_s2_reg;
    logic                  addr_ok;                 // valid address phase
    logic                  wr_ctrl;                 // control write now
    logic                  wr_stat;                 // status write now
    logic                  wr_clk;                  // clock select write now
    logic                  restart;                 // restart strobe
    logic                  osc_edge;                // selected source edge
    logic                  tick;                    // count clock enable
    logic                  counting;                // clock fed and running
    logic [2:0]            sel_mask;                // one-hot selected osc
    logic [2:0]            osc_rise;                // rising edges

    // ======================================================================
    // helpers
    // ======================================================================
    // terminal divider count for a source and divider code
    function automatic logic [14:0] div_tc(input logic [1:0] src,
                                           input logic [1:0] dv);
        logic [14:0] tc;
        tc = rwt_pkg::TC_LOW;
        if (src != rwt_pkg::SRC_LOW) begin
            case (dv)
                2'h0:    tc = rwt_pkg::TC_4096;
                2'h1:    tc = rwt_pkg::TC_8192;
                2'h2:    tc = rwt_pkg::TC_16384;
                default: tc = rwt_pkg::TC_32768;
            endcase
        end
        return tc;
    endfunction

    // one-hot mask of the oscillator a source code names
    function automatic logic [2:0] src_mask(input logic [1:0] src);
        logic [2:0] m;
        m = 3'h0;
        if (src == rwt_pkg::SRC_IRC) begin
            m = 3'h1;
        end else if (src == rwt_pkg::SRC_LOW) begin
            m = 3'h2;
        end else if (src == rwt_pkg::SRC_HIGH) begin
            m = 3'h4;
        end
        return m;
    endfunction

    // ======================================================================
    // ahb-lite slave
    // ======================================================================
    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && hready && (htrans == rwt_pkg::HTRANS_NONSEQ);

    // capture write address phase, word writes only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 30'h0000_0000;
        end else begin
            wr_pend_reg <= addr_ok && hwrite && (hsize == rwt_pkg::HSIZE_WORD);
            wr_idx_reg  <= haddr[31:2];
        end
    end

    // data phase write strobes, unmapped indexes fall through
    always_comb begin
        wr_ctrl = 1'b0;
        wr_stat = 1'b0;
        wr_clk  = 1'b0;
        if (!wr_pend_reg) begin
            wr_ctrl = 1'b0;
        end else if (wr_idx_reg == rwt_pkg::IDX_CONTROL) begin
            wr_ctrl = 1'b1;
        end else if (wr_idx_reg == rwt_pkg::IDX_STATUS) begin
            wr_stat = 1'b1;
        end else if (wr_idx_reg == rwt_pkg::IDX_CLOCK_SEL) begin
            wr_clk = 1'b1;
        end
    end

    // restart fires only on a written one
    assign restart = wr_ctrl && hwdata[rwt_pkg::CTL_RESTART_BIT];

    // read data registered in the address phase; status may move one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= 32'h0000_0000;
            if (haddr[31:2] == rwt_pkg::IDX_CONTROL) begin
                hrdata[3:0] <= ctrl_reg.run_key; // restart reads 0
            end else if (haddr[31:2] == rwt_pkg::IDX_STATUS) begin
                hrdata[rwt_pkg::ST_ACTION_BIT] <= ctrl_reg.action_sel;
                hrdata[rwt_pkg::ST_FLAG_BIT]   <= flag_reg;
            end else if (haddr[31:2] == rwt_pkg::IDX_CLOCK_SEL) begin
                hrdata[7:0] <= clk_sel_reg;
            end
        end
    end

    // ======================================================================
    // registers
    // ======================================================================
    // clock select; source and divider locked while clock enabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_sel_reg <= rwt_pkg::CLK_SEL_RESET;
        end else if (wr_clk) begin
            clk_sel_reg.enable_key <= hwdata[3:0];
            if (clk_sel_reg.enable_key == rwt_pkg::KEY_STOP) begin
                clk_sel_reg.divider <= hwdata[7:6];
                clk_sel_reg.source  <= hwdata[5:4];
            end
        end
    end

    // run key and overflow action; writable with the clock stopped too
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= rwt_pkg::CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg.run_key <= hwdata[3:0];
            end
            if (wr_stat) begin
                ctrl_reg.action_sel <= hwdata[rwt_pkg::ST_ACTION_BIT];
            end
        end
    end

    // ======================================================================
    // oscillator synchronisers
    // ======================================================================
    // sources must run below half of hclk, or edges are lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_s1_reg <= 3'h0;
            osc_s2_reg <= 3'h0;
            osc_s3_reg <= 3'h0;
        end else begin
            osc_s1_reg <= {high_speed_osc, low_speed_osc, internal_rc_osc};
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
        end
    end

    assign osc_rise = osc_s2_reg & ~osc_s3_reg;
    assign sel_mask = src_mask(clk_sel_reg.source);
    // reserved source yields no edges, so the counter never moves
    assign osc_edge = |(osc_rise & sel_mask);

    // stop requests for the selected oscillator are refused
    assign osc_stop_grant = osc_stop_req & ~sel_mask;

    // ======================================================================
    // count clock divider
    // ======================================================================
    // divider runs only while the enable key lets the clock through
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_reg <= 15'h0000;
        end else if (restart ||
                     clk_sel_reg.enable_key == rwt_pkg::KEY_STOP) begin
            pre_reg <= 15'h0000;
        end else if (osc_edge) begin
            if (pre_reg >= div_tc(clk_sel_reg.source,
                                  clk_sel_reg.divider)) begin
                pre_reg <= 15'h0000;
            end else begin
                pre_reg <= pre_reg + 15'h0001;
            end
        end
    end

    assign tick = osc_edge &&
                  (pre_reg >= div_tc(clk_sel_reg.source, clk_sel_reg.divider));
    assign counting = (clk_sel_reg.enable_key != rwt_pkg::KEY_STOP) &&
                      (ctrl_reg.run_key != rwt_pkg::KEY_STOP);

    // ======================================================================
    // watchdog counter
    // ======================================================================
    // restart beats a coincident tick; cpu halt does not gate counting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= 10'h000;
        end else if (restart) begin
            count_reg <= 10'h000;
        end else if (tick && counting) begin
            count_reg <= count_reg + 10'h001;
        end
    end

    // overflow on the wrap from the last value; 1024 ticks after restart
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_reg <= 1'b0;
        end else begin
            ovf_reg <= !restart && tick && counting &&
                       (count_reg == rwt_pkg::CNT_LAST);
        end
    end

    // ======================================================================
    // overflow flag and outputs
    // ======================================================================
    // flag set wins over a same-cycle restart
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_reg <= 1'b0;
        end else if (ovf_reg) begin
            flag_reg <= 1'b1;
        end else if (restart) begin
            flag_reg <= 1'b0;
        end
    end

    // sleep comes from the power controller, possibly on another clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_s1_reg <= 1'b0;
            sleep_s2_reg <= 1'b0;
        end else begin
            sleep_s1_reg <= cpu_sleep;
            sleep_s2_reg <= sleep_s1_reg;
        end
    end

    // pending overflow held while asleep; new overflow wins over restart
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_reg <= 1'b0;
        end else if (ovf_reg) begin
            pend_reg <= 1'b1;
        end else if (restart || !sleep_s2_reg) begin
            pend_reg <= 1'b0;
        end
    end

    // output pulses, two cycles for an awake overflow, one after a wake; released only when awake
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nmi_out   <= 1'b0;
            reset_out <= 1'b0;
        end else begin
            nmi_out   <= (ovf_reg || pend_reg) && !sleep_s2_reg &&
                         (ctrl_reg.action_sel == rwt_pkg::ACT_NMI);
            reset_out <= (ovf_reg || pend_reg) && !sleep_s2_reg &&
                         (ctrl_reg.action_sel == rwt_pkg::ACT_RESET);
        end
    end

    // ======================================================================
    // assertions
    // ======================================================================
    a_restart_clears: assert property (
        @(posedge hclk) disable iff (!hresetn)
        restart |=> (count_reg == 10'h000) && (pre_reg == 15'h0000))
        else $error("restart did not clear the counter");

    a_stopped_holds: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_reg.run_key == rwt_pkg::KEY_STOP) && !restart
        |=> count_reg == $past(count_reg))
        else $error("counter moved while stopped");

    a_key_gates_div: assert property (
        @(posedge hclk) disable iff (!hresetn)
        clk_sel_reg.enable_key == rwt_pkg::KEY_STOP |=> pre_reg == 15'h0000)
        else $error("divider ran with clock disabled");

    a_sel_locked: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_clk && (clk_sel_reg.enable_key != rwt_pkg::KEY_STOP)
        |=> $stable(clk_sel_reg.source) && $stable(clk_sel_reg.divider))
        else $error("source changed while clock enabled");

    a_ovf_at_wrap: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ovf_reg |-> $past(count_reg) == rwt_pkg::CNT_LAST && count_reg == 0)
        else $error("overflow without counter wrap");

    a_flag_on_ovf: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ovf_reg |=> flag_reg)
        else $error("overflow did not set the flag");

    a_sleep_blocks: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $past(sleep_s2_reg) |-> !nmi_out && !reset_out)
        else $error("overflow output during sleep");

    a_awake_fires: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ovf_reg && !sleep_s2_reg |=> nmi_out != reset_out)
        else $error("awake overflow gave no single action");

    a_osc_guard: assert property (
        @(posedge hclk) disable iff (!hresetn)
        clk_sel_reg.source == 2'h3 || !osc_stop_grant[clk_sel_reg.source])
        else $error("selected oscillator stop granted");

    a_rsvd_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        addr_ok && !hwrite |=> hrdata[31:8] == 24'h00_0000)
        else $error("reserved read bits not zero");
endmodule

// ===== pkg/rwt_pkg.sv
// ==========================================================================
// runaway watchdog timer shared constants and types
// ==========================================================================
package rwt_pkg;

    // ======================================================================
    // bus and register geometry
    // ======================================================================
    localparam int unsigned DATA_W = 32;            // ahb data width
    localparam int unsigned REG_W  = 8;             // every register is 8 bit
    // printed offsets are register indexes, byte address is four times them
    localparam logic [29:0] IDX_CONTROL   = 30'h0000_5040;
    localparam logic [29:0] IDX_STATUS    = 30'h0000_5041;
    localparam logic [29:0] IDX_CLOCK_SEL = 30'h0000_5070;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;

    // ======================================================================
    // field positions
    // ======================================================================
    localparam int unsigned CTL_RESTART_BIT = 4;    // write-only restart
    localparam int unsigned CTL_RUN_LSB     = 0;    // run/stop key [3:0]
    localparam int unsigned ST_ACTION_BIT   = 1;    // 0 nmi, 1 reset
    localparam int unsigned ST_FLAG_BIT     = 0;    // overflow nmi flag
    localparam int unsigned CLK_DIV_LSB     = 6;    // divider select [7:6]
    localparam int unsigned CLK_SRC_LSB     = 4;    // source select [5:4]
    localparam int unsigned CLK_EN_LSB      = 0;    // enable key [3:0]

    // ======================================================================
    // codes and reset values
    // ======================================================================
    localparam logic [3:0] KEY_STOP   = 4'ha;       // stop code of both keys
    localparam logic [1:0] SRC_IRC    = 2'h0;       // internal rc oscillator
    localparam logic [1:0] SRC_LOW    = 2'h1;       // low-speed oscillator
    localparam logic [1:0] SRC_HIGH   = 2'h2;       // high-speed oscillator
    localparam logic [1:0] DIV_RESET  = 2'h0;
    localparam logic       ACT_NMI    = 1'h0;
    localparam logic       ACT_RESET  = 1'h1;

    // ======================================================================
    // timing: divider terminal counts in oscillator edges
    // ======================================================================
    localparam logic [14:0] TC_LOW   = 15'h007f;    // 1/128
    localparam logic [14:0] TC_4096  = 15'h0fff;
    localparam logic [14:0] TC_8192  = 15'h1fff;
    localparam logic [14:0] TC_16384 = 15'h3fff;
    localparam logic [14:0] TC_32768 = 15'h7fff;
    localparam int unsigned CNT_W    = 10;          // up counter width
    localparam logic [9:0]  CNT_LAST = 10'h3ff;     // value before wrap
    // timeout in source periods, 128 * 1024 on the low-speed source
    localparam int unsigned TIMEOUT_OSC_PERIODS = 131072;

    // ======================================================================
    // carriers
    // ======================================================================
    typedef struct packed {
        logic [1:0] divider;                        // divider select
        logic [1:0] source;                         // source select
        logic [3:0] enable_key;                     // count clock gate
    } rwt_clk_sel_t;

    typedef struct packed {
        logic [3:0] run_key;                        // run/stop key
        logic       action_sel;                     // overflow action
    } rwt_ctrl_t;

    localparam rwt_clk_sel_t CLK_SEL_RESET = '{DIV_RESET, SRC_LOW, KEY_STOP};
    localparam rwt_ctrl_t    CTRL_RESET    = '{KEY_STOP, ACT_NMI};

endpackage

// ===== test/rwt_cpu_model.sv
`timescale 1ns/1ps
// ==========================================================================
// cpu core model: takes overflow pulses, owns the sleep level
// ==========================================================================
module rwt_cpu_model (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic nmi_out,
    input  wire logic reset_out,
    input  wire logic sleep_req,
    output logic      cpu_sleep,
    output int        nmi_seen,
    output int        rst_seen
);
    // sleep level follows the request one edge later, like a sleep opcode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_sleep <= 1'b0;
        end else begin
            cpu_sleep <= sleep_req;
        end
    end
    // pulses are only counted; a real core would stretch the reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nmi_seen <= 0;
            rst_seen <= 0;
        end else begin
            if (nmi_out) nmi_seen <= nmi_seen + 1;
            if (reset_out) rst_seen <= rst_seen + 1;
        end
    end
endmodule

// ===== test/test_watchdog_timer.sv
`timescale 1ns/1ps
`define CHK(n, e, g) check_val(n, e, g)
// ==========================================================================
// bench for the runaway watchdog timer
// ==========================================================================
module test_watchdog_timer;
    logic        hclk = 1'b0;          // 200 mhz bus clock
    logic        hresetn = 1'b0;       // async reset, low
    logic        hsel = 1'b1;          // single slave, always selected
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, cpu_sleep, nmi_out, reset_out;
    logic        low_speed_osc = 1'b0; // 4 hclk period, 2 high 2 low
    logic [2:0]  osc_stop_req = 3'h0;
    logic [2:0]  osc_stop_grant;
    logic        sleep_req = 1'b0;
    logic [1:0]  osc_div = 2'h0;
    int          lo_edges = 0;         // rising edges of the slow source
    int          nmi_seen, rst_seen, bad_count = 0, compares = 0;
    logic [31:0] rd;
    localparam int N = 131072;         // source periods to timeout

    // ======================================================================
    // clock, slow oscillator, design and cpu
    // ======================================================================
    always #2.5 hclk = ~hclk;
    // slow source kept well under hclk/2 so the synchroniser sees each edge
    always @(posedge hclk) begin
        osc_div <= osc_div + 2'h1;
        if (osc_div == 2'h3) begin
            low_speed_osc <= 1'b1;
            lo_edges <= lo_edges + 1;
        end
        if (osc_div == 2'h1) low_speed_osc <= 1'b0;
    end
    rwt_watchdog_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .internal_rc_osc(1'b0),
        .low_speed_osc(low_speed_osc), .high_speed_osc(1'b0),
        .cpu_sleep(cpu_sleep), .osc_stop_req(osc_stop_req),
        .osc_stop_grant(osc_stop_grant), .nmi_out(nmi_out),
        .reset_out(reset_out));
    rwt_cpu_model cpu_u (.hclk(hclk), .hresetn(hresetn), .nmi_out(nmi_out),
        .reset_out(reset_out), .sleep_req(sleep_req), .cpu_sleep(cpu_sleep),
        .nmi_seen(nmi_seen), .rst_seen(rst_seen));

    // ======================================================================
    // compare, verdict and ahb-lite single transfers
    // ======================================================================
    task automatic check_val(input string n, input logic [31:0] e,
                             input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // address phase held until hready, then data phase until hready
    task automatic bus(input logic [29:0] idx, input logic wr,
                       input logic [31:0] wd);
        @(posedge hclk);
        haddr <= {idx, 2'b00};
        hwrite <= wr;
        htrans <= rwt_pkg::HTRANS_NONSEQ;
        hsize <= rwt_pkg::HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input string n, input logic [29:0] idx,
                        input logic [31:0] e);
        bus(idx, 1'b0, '0);
        `CHK(n, e, rd);
    endtask

    // ======================================================================
    // scenarios
    // ======================================================================
    task automatic t_reset_vals;
        rchk("control", rwt_pkg::IDX_CONTROL, 32'h0000_000a);
        rchk("status", rwt_pkg::IDX_STATUS, 32'h0000_0000);
        rchk("clk_sel", rwt_pkg::IDX_CLOCK_SEL, 32'h0000_001a);
        rchk("unmapped", 30'h0000_5050, 32'h0000_0000);
    endtask
    task automatic t_osc_guard;
        osc_stop_req <= 3'h7;
        rchk("clk_sel", rwt_pkg::IDX_CLOCK_SEL, 32'h0000_001a);
        `CHK("grant_low", 32'h5, {29'h0, osc_stop_grant});
        bus(rwt_pkg::IDX_CLOCK_SEL, 1'b1, 32'h0000_00e5);
        rchk("clk_sel", rwt_pkg::IDX_CLOCK_SEL, 32'h0000_00e5);
        `CHK("grant_high", 32'h3, {29'h0, osc_stop_grant});
        // key is now open, so source and divider must hold
        bus(rwt_pkg::IDX_CLOCK_SEL, 1'b1, 32'h0000_001a);
        rchk("clk_sel", rwt_pkg::IDX_CLOCK_SEL, 32'h0000_00ea);
        bus(rwt_pkg::IDX_CLOCK_SEL, 1'b1, 32'h0000_001a);
        rchk("clk_sel", rwt_pkg::IDX_CLOCK_SEL, 32'h0000_001a);
        osc_stop_req <= 3'h0;
    endtask
    // one full timeout on the slow source, overflow landing in sleep
    task automatic t_overflow;
        int t0;
        sleep_req <= 1'b1;
        bus(rwt_pkg::IDX_CLOCK_SEL, 1'b1, 32'h0000_0015);
        bus(rwt_pkg::IDX_CONTROL, 1'b1, 32'h0000_0015);
        t0 = lo_edges;
        while (lo_edges - t0 < N - 3) @(posedge hclk);
        rchk("flag_early", rwt_pkg::IDX_STATUS, 32'h0000_0000);
        while (lo_edges - t0 < N + 1) @(posedge hclk);
        repeat (10) @(posedge hclk);
        rchk("flag_set", rwt_pkg::IDX_STATUS, 32'h0000_0001);
        `CHK("nmi_in_sleep", 32'h0, nmi_seen);
        sleep_req <= 1'b0;
        repeat (10) @(posedge hclk);
        `CHK("nmi_after", 32'h1, nmi_seen);
        `CHK("rst_count", 32'h0, rst_seen);
        bus(rwt_pkg::IDX_CONTROL, 1'b1, 32'h0000_0015);
        rchk("flag_clr", rwt_pkg::IDX_STATUS, 32'h0000_0000);
        bus(rwt_pkg::IDX_STATUS, 1'b1, 32'h0000_0003);
        rchk("action", rwt_pkg::IDX_STATUS, 32'h0000_0002);
        bus(rwt_pkg::IDX_CONTROL, 1'b1, 32'h0000_001a);
        rchk("ctl_stop", rwt_pkg::IDX_CONTROL, 32'h0000_000a);
    endtask

    // ======================================================================
    // main sequence and watchdog
    // ======================================================================
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_vals();
        t_osc_guard();
        t_overflow();
        end_sim();
    end
    // full timeout takes about 2.6 ms of slow source edges
    initial begin
        #4_000_000;
        bad_count++;
        end_sim();
    end
endmodule
